//--- hw/adc_ctrl_regs.svh
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// Access codes; DAC writes ignore the top bit
`define ACC_WR_DAC_ONE_LOW  3'h2
`define ACC_WR_DAC_TWO_LOW  3'h5
`define ACC_RD_DAC_ONE      4'h3
`define ACC_RD_DAC_TWO      4'h6
`define ACC_WR_SEQ          4'h9
`define ACC_RD_SEQ          4'hB

// DAC layout
`define DAC_STORE_MSB       10
`define DAC_PD_BIT          10
`define DAC_CODE_MSB        9
`define DAC_STORE_RESET     11'h7FF
`define DAC_RSVD_ZERO       5'h00

// Sequencer layout
`define SEQ_RESET           16'h0000
`define SEQ_MODE_MSB        15
`define SEQ_MODE_LSB        14
`define SEQ_LEN_LSB         12
`define SEQ_C1_LSB          10
`define SEQ_C2_LSB          8
`define SEQ_C3_LSB          6
`define SEQ_C4_LSB          4
`define SEQ_POS_LSB         2
`define SEQ_DEPTH_LSB       0

// Small codes
`define MODE_HOLD_BUSY      2'h3
`define CODE_ZERO2          2'h0
`define CODE_ONE2           2'h1
`define CODE_TWO2           2'h2
`define CODE_THREE2         2'h3
`define FIFO_DEPTH_MAX      4
`define PAIR_WORD_ZERO      32'h00000000

`endif

//--- hw/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    typedef logic [15:0] word_t;
    typedef logic [31:0] pair_word_t;
    typedef logic [1:0]  code2_t;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_RUN,
        CONV_GAP
    } conv_state_e;

    typedef enum logic {
        RD_IDLE,
        RD_BURST
    } read_state_e;

endpackage : adc_ctrl_pkg

//--- hw/channel_result_fifo.sv
`timescale 1ns/1ns
`include "adc_ctrl_regs.svh"

module channel_result_fifo
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    // Fill side
    input  wire logic       push_i,
    input  wire pair_word_t data_i,
    input  wire logic       clear_i,
    input  wire code2_t     depth_sel_i,
    // Read side
    input  wire code2_t     rd_index_i,
    output pair_word_t      rd_data_o,
    output logic            full_o
);

    pair_word_t mem [0:`FIFO_DEPTH_MAX-1];
    logic [2:0] fill;
    logic [2:0] depth_count;

    assign depth_count = {1'b0, depth_sel_i} + 3'h1;
    assign full_o      = (fill >= depth_count);
    assign rd_data_o   = mem[rd_index_i];

    ////////////////////////////////////////////////////////////////////////
    // Entry 0 is the newest; a push when full drops the oldest
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < `FIFO_DEPTH_MAX; i++) begin
                mem[i] <= `PAIR_WORD_ZERO;
            end
        end else if (push_i) begin
            mem[0] <= data_i;
            for (int i = 1; i < `FIFO_DEPTH_MAX; i++) begin
                mem[i] <= clear_i ? `PAIR_WORD_ZERO : mem[i-1];
            end
        end else if (clear_i) begin
            for (int i = 0; i < `FIFO_DEPTH_MAX; i++) begin
                mem[i] <= `PAIR_WORD_ZERO;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fill <= 3'h0;
        end else if (push_i && clear_i) begin
            fill <= 3'h1;
        end else if (clear_i) begin
            fill <= 3'h0;
        end else if (push_i && !full_o) begin
            fill <= fill + 3'h1;
        end else if (!push_i && fill > depth_count) begin
            // Depth lowered: entries past it are stale
            fill <= depth_count;
        end
    end

endmodule : channel_result_fifo

//--- hw/adc_refdac_sequencer_fifo_ctrl.sv
// Function
// - DAC one bit 10 set powers path one down.
// - DAC two bit 10 does so for path two.
// - Bits 9:0 hold the DAC code, MSB first.
// - Both DAC registers reset to 07FF.
// - Sequencer drives the mux only in pseudo auto mode.
// - Sequencer on, with FIFO on or mode 11: one read strobe gives all results.
// - Each pair has its own four-deep FIFO.
// - Push into a full FIFO drops the oldest.
// - Sequencer start clears a full FIFO to zero.
// - FIFO off: two words per read, mode 11 per sequence.
// - FIFO on, fully differential: twice depth words.
// - FIFO on, pseudo: twice length times depth words.
// - Mode bits 15:14 set starts per sequence and busy in half-clock mode.
// - Length bits 13:12 give two to four slots.
// - Bits 11:10 pick slot one pair, then later slots.
// - Sequencer register resets to zero.
// - Slot code picks input pair zero to three.
// - Depth bits 1:0 give one to four results.
// - Position bits 3:2 show the next slot.
// - Access code selects register read or write.
`timescale 1ns/1ns
`include "adc_ctrl_regs.svh"

module adc_refdac_sequencer_fifo_ctrl
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic   core_clk_i,
    input  wire logic   reset_n_i,
    // Register access from the serial front end
    input  wire logic   reg_access_i,
    input  wire logic [3:0] access_code_i,
    input  wire word_t  reg_wr_data_i,
    output word_t       reg_rd_data_o,
    output logic        reg_rd_valid_o,
    // Configuration bits held elsewhere
    input  wire logic   pseudo_diff_mode_i,
    input  wire logic   auto_channel_select_i,
    input  wire logic   half_clock_mode_i,
    input  wire logic   fifo_enable_bit_i,
    input  wire code2_t manual_pair_i,
    // Host strobes from pins
    input  wire logic   conversion_start_strobe_i,
    input  wire logic   read_strobe_i,
    // Conversion engine
    input  wire logic   conv_done_i,
    input  wire word_t  result_a_i,
    input  wire word_t  result_b_i,
    output logic        conv_trigger_o,
    output code2_t      channel_pair_o,
    output logic        busy_o,
    // Reference paths
    output logic        reference_output_one_enable_o,
    output logic [9:0]  reference_output_one_code_o,
    output logic        reference_output_two_enable_o,
    output logic [9:0]  reference_output_two_code_o,
    // Result words toward the serial outputs
    output word_t       serial_out_a_o,
    output word_t       serial_out_b_o,
    output logic        serial_out_valid_o,
    output logic        serial_out_last_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [`DAC_STORE_MSB:0] reference_dac_one_ctrl;
    logic [`DAC_STORE_MSB:0] reference_dac_two_ctrl;
    word_t       sequencer_fifo_ctrl;
    code2_t      sequence_position;
    conv_state_e conv_state;
    read_state_e read_state;
    logic        start_sync1, start_sync2, start_prev;
    logic        read_sync1, read_sync2, read_prev;
    logic        start_rise, read_rise;
    logic        seq_active;
    logic        burst_mode;
    logic        hold_busy;
    code2_t      seq_mode;
    code2_t      sequence_length_sel;
    code2_t      fifo_depth_sel;
    code2_t      conv_pair;
    code2_t      next_pair;
    logic        fifo_clear;
    logic        fifo_push [0:3];
    logic        fifo_full [0:3];
    pair_word_t  fifo_rd_data [0:3];
    code2_t      rd_entry, rd_entry_first;
    code2_t      rd_slot, rd_slot_last;
    logic        rd_from_slots;
    code2_t      rd_pair;
    logic        seq_write;

    assign seq_mode            = sequencer_fifo_ctrl[`SEQ_MODE_MSB:`SEQ_MODE_LSB];
    assign sequence_length_sel = sequencer_fifo_ctrl[`SEQ_LEN_LSB +: 2];
    assign fifo_depth_sel      = sequencer_fifo_ctrl[`SEQ_DEPTH_LSB +: 2];
    // Length code zero: slots inactive
    assign seq_active = pseudo_diff_mode_i && auto_channel_select_i &&
                        (sequence_length_sel != `CODE_ZERO2);
    assign seq_write  = reg_access_i && (access_code_i == `ACC_WR_SEQ);

    // Slot code to input pair
    function automatic code2_t slot_channel(input word_t seq, input code2_t slot);
        case (slot)
            `CODE_ZERO2: slot_channel = seq[`SEQ_C1_LSB +: 2];
            `CODE_ONE2:  slot_channel = seq[`SEQ_C2_LSB +: 2];
            `CODE_TWO2:  slot_channel = seq[`SEQ_C3_LSB +: 2];
            default:     slot_channel = seq[`SEQ_C4_LSB +: 2];
        endcase
    endfunction : slot_channel

    // Next slot, wrapping after the last
    function automatic code2_t next_slot(input code2_t pos, input code2_t last);
        next_slot = (pos >= last) ? `CODE_ZERO2 : pos + `CODE_ONE2;
    endfunction : next_slot

    ////////////////////////////////////////////////////////////////////////
    // Two-stage sync; pins are asynchronous
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            start_sync1 <= 1'b0;
            start_sync2 <= 1'b0;
            start_prev  <= 1'b0;
            read_sync1  <= 1'b0;
            read_sync2  <= 1'b0;
            read_prev   <= 1'b0;
        end else begin
            start_sync1 <= conversion_start_strobe_i;
            start_sync2 <= start_sync1;
            start_prev  <= start_sync2;
            read_sync1  <= read_strobe_i;
            read_sync2  <= read_sync1;
            read_prev   <= read_sync2;
        end
    end

    // Host keeps strobes apart
    assign start_rise = start_sync2 && !start_prev;
    assign read_rise  = read_sync2 && !read_prev;

    ////////////////////////////////////////////////////////////////////////
    // Reserved DAC bits are not stored
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reference_dac_one_ctrl <= `DAC_STORE_RESET;
        end else if (reg_access_i && access_code_i[2:0] == `ACC_WR_DAC_ONE_LOW) begin
            reference_dac_one_ctrl <= reg_wr_data_i[`DAC_STORE_MSB:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reference_dac_two_ctrl <= `DAC_STORE_RESET;
        end else if (reg_access_i && access_code_i[2:0] == `ACC_WR_DAC_TWO_LOW) begin
            reference_dac_two_ctrl <= reg_wr_data_i[`DAC_STORE_MSB:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sequencer_fifo_ctrl <= `SEQ_RESET;
        end else if (seq_write) begin
            sequencer_fifo_ctrl <= reg_wr_data_i;
        end
    end

    // Reads answer one cycle later
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rd_data_o  <= 16'h0000;
            reg_rd_valid_o <= 1'b0;
        end else begin
            reg_rd_valid_o <= 1'b0;
            if (reg_access_i && access_code_i == `ACC_RD_DAC_ONE) begin
                reg_rd_data_o  <= {`DAC_RSVD_ZERO, reference_dac_one_ctrl};
                reg_rd_valid_o <= 1'b1;
            end else if (reg_access_i && access_code_i == `ACC_RD_DAC_TWO) begin
                reg_rd_data_o  <= {`DAC_RSVD_ZERO, reference_dac_two_ctrl};
                reg_rd_valid_o <= 1'b1;
            end else if (reg_access_i && access_code_i == `ACC_RD_SEQ) begin
                // Position reads live; stored bits unused
                reg_rd_data_o  <= {sequencer_fifo_ctrl[15:4], sequence_position,
                                   fifo_depth_sel};
                reg_rd_valid_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference path outputs
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reference_output_one_enable_o <= 1'b0;
            reference_output_one_code_o   <= 10'h3FF;
            reference_output_two_enable_o <= 1'b0;
            reference_output_two_code_o   <= 10'h3FF;
        end else begin
            reference_output_one_enable_o <= !reference_dac_one_ctrl[`DAC_PD_BIT];
            reference_output_one_code_o   <= reference_dac_one_ctrl[`DAC_CODE_MSB:0];
            reference_output_two_enable_o <= !reference_dac_two_ctrl[`DAC_PD_BIT];
            reference_output_two_code_o   <= reference_dac_two_ctrl[`DAC_CODE_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion control
    // Whole-sequence starts exist in half-clock mode only
    assign burst_mode = seq_active && seq_mode[1] && half_clock_mode_i;
    assign hold_busy  = burst_mode && (seq_mode == `MODE_HOLD_BUSY);
    // Manual pair outside the sequencer
    assign next_pair  = seq_active ? slot_channel(sequencer_fifo_ctrl, sequence_position)
                                   : manual_pair_i;
    // Sequence start over a full FIFO wipes all
    assign fifo_clear = seq_active && fifo_enable_bit_i && start_rise &&
                        (conv_state == CONV_IDLE) &&
                        (sequence_position == `CODE_ZERO2) && fifo_full[next_pair];

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            conv_state     <= CONV_IDLE;
            conv_trigger_o <= 1'b0;
            busy_o         <= 1'b0;
            channel_pair_o <= `CODE_ZERO2;
            conv_pair      <= `CODE_ZERO2;
        end else begin
            conv_trigger_o <= 1'b0;
            case (conv_state)
                CONV_IDLE: begin
                    if (start_rise) begin
                        conv_trigger_o <= 1'b1;
                        busy_o         <= 1'b1;
                        channel_pair_o <= next_pair;
                        conv_pair      <= next_pair;
                        conv_state     <= CONV_RUN;
                    end
                end
                CONV_RUN: begin
                    if (conv_done_i) begin
                        if (burst_mode && sequence_position != `CODE_ZERO2) begin
                            // Busy drops between slots unless held
                            busy_o     <= hold_busy;
                            conv_state <= CONV_GAP;
                        end else begin
                            busy_o     <= 1'b0;
                            conv_state <= CONV_IDLE;
                        end
                    end
                end
                CONV_GAP: begin
                    conv_trigger_o <= 1'b1;
                    busy_o         <= 1'b1;
                    channel_pair_o <= next_pair;
                    conv_pair      <= next_pair;
                    conv_state     <= CONV_RUN;
                end
                default: begin
                    conv_state <= CONV_IDLE;
                end
            endcase
        end
    end

    // Steps per slot; a write restarts it
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sequence_position <= `CODE_ZERO2;
        end else if (seq_write || !seq_active) begin
            sequence_position <= `CODE_ZERO2;
        end else if ((conv_state == CONV_IDLE && start_rise) || conv_state == CONV_GAP) begin
            sequence_position <= next_slot(sequence_position, sequence_length_sel);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One FIFO per pair; depth one with FIFO off
    for (genvar p = 0; p < 4; p++) begin : g_pair_fifo
        assign fifo_push[p] = conv_done_i && (conv_state == CONV_RUN) &&
                              (conv_pair == 2'(p));
        channel_result_fifo u_fifo (
            .core_clk_i  (core_clk_i),
            .reset_n_i   (reset_n_i),
            .push_i      (fifo_push[p]),
            .data_i      ({result_a_i, result_b_i}),
            .clear_i     (fifo_clear),
            .depth_sel_i (fifo_enable_bit_i ? fifo_depth_sel : `CODE_ZERO2),
            .rd_index_i  (rd_entry),
            .rd_data_o   (fifo_rd_data[p]),
            .full_o      (fifo_full[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Burst: oldest entry first, slots in order
    assign rd_pair = rd_from_slots ? slot_channel(sequencer_fifo_ctrl, rd_slot) : conv_pair;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            read_state         <= RD_IDLE;
            rd_entry           <= `CODE_ZERO2;
            rd_entry_first     <= `CODE_ZERO2;
            rd_slot            <= `CODE_ZERO2;
            rd_slot_last       <= `CODE_ZERO2;
            rd_from_slots      <= 1'b0;
            serial_out_a_o     <= 16'h0000;
            serial_out_b_o     <= 16'h0000;
            serial_out_valid_o <= 1'b0;
            serial_out_last_o  <= 1'b0;
        end else begin
            serial_out_valid_o <= 1'b0;
            serial_out_last_o  <= 1'b0;
            case (read_state)
                RD_IDLE: begin
                    if (read_rise) begin
                        // FIFO off: one pair; on: depth pairs
                        rd_entry       <= fifo_enable_bit_i ? fifo_depth_sel : `CODE_ZERO2;
                        rd_entry_first <= fifo_enable_bit_i ? fifo_depth_sel : `CODE_ZERO2;
                        rd_slot        <= `CODE_ZERO2;
                        // Sequencer multiplies by length when FIFO on or mode 11
                        rd_from_slots  <= seq_active &&
                                          (fifo_enable_bit_i || seq_mode == `MODE_HOLD_BUSY);
                        rd_slot_last   <= (seq_active &&
                                          (fifo_enable_bit_i || seq_mode == `MODE_HOLD_BUSY))
                                          ? sequence_length_sel : `CODE_ZERO2;
                        read_state     <= RD_BURST;
                    end
                end
                RD_BURST: begin
                    serial_out_a_o     <= fifo_rd_data[rd_pair][31:16];
                    serial_out_b_o     <= fifo_rd_data[rd_pair][15:0];
                    serial_out_valid_o <= 1'b1;
                    if (rd_slot != rd_slot_last) begin
                        rd_slot <= rd_slot + `CODE_ONE2;
                    end else if (rd_entry != `CODE_ZERO2) begin
                        rd_slot  <= `CODE_ZERO2;
                        rd_entry <= rd_entry - `CODE_ONE2;
                    end else begin
                        serial_out_last_o <= 1'b1;
                        read_state        <= RD_IDLE;
                    end
                end
                default: begin
                    read_state <= RD_IDLE;
                end
            endcase
        end
    end

endmodule : adc_refdac_sequencer_fifo_ctrl

//--- bench/host_strobe_model.sv
`timescale 1ns/1ns
module host_strobe_model (
    // Clock and requests
    input  wire logic core_clk_i,
    input  wire logic conv_req_i,
    input  wire logic read_req_i,
    // Strobe pins
    output logic      conv_strobe_o,
    output logic      read_strobe_o
);
    logic [1:0] conv_left;
    logic [1:0] read_left;
    initial begin
        conv_left = 2'h0;
        read_left = 2'h0;
    end
    // Three cycles high clears the two-stage pin synchroniser
    always @(posedge core_clk_i) begin
        conv_left <= conv_req_i ? 2'h3 : conv_left - {1'b0, conv_left != 2'h0};
        read_left <= read_req_i ? 2'h3 : read_left - {1'b0, read_left != 2'h0};
    end
    assign conv_strobe_o = conv_left != 2'h0;
    assign read_strobe_o = read_left != 2'h0;
endmodule : host_strobe_model

//--- bench/adc_ctrl_properties.sv
`timescale 1ns/1ns
module adc_ctrl_properties
    import adc_ctrl_pkg::*;
(
    // Watched ports
    input wire logic       core_clk_i,
    input wire logic       reset_n_i,
    input wire logic       reg_access_i,
    input wire logic [3:0] access_code_i,
    input wire word_t      reg_wr_data_i,
    input wire word_t      reg_rd_data_o,
    input wire logic       reg_rd_valid_o,
    input wire logic       pseudo_diff_mode_i,
    input wire logic       auto_channel_select_i,
    input wire code2_t     manual_pair_i,
    input wire logic       conv_trigger_o,
    input wire code2_t     channel_pair_o,
    input wire logic       busy_o,
    input wire logic       reference_output_one_enable_o,
    input wire logic       reference_output_two_enable_o,
    input wire logic       serial_out_valid_o,
    input wire logic       serial_out_last_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    chk_read_answer: assert property (
        reg_access_i && access_code_i inside {4'h3, 4'h6, 4'hB} |=> reg_rd_valid_o)
        else $error("read not answered");
    chk_answer_cause: assert property (
        reg_rd_valid_o |-> $past(reg_access_i)) else $error("stray read answer");
    chk_reserved_zero: assert property (
        reg_access_i && access_code_i == 4'h3 |=> reg_rd_data_o[15:11] == 5'h00)
        else $error("reserved bits read nonzero");
    chk_dac_one_enable: assert property (
        reg_access_i && access_code_i[2:0] == 3'h2
        |=> ##1 reference_output_one_enable_o == !$past(reg_wr_data_i[10], 2))
        else $error("dac one enable wrong");
    chk_dac_two_enable: assert property (
        reg_access_i && access_code_i[2:0] == 3'h5
        |=> ##1 reference_output_two_enable_o == !$past(reg_wr_data_i[10], 2))
        else $error("dac two enable wrong");
    chk_manual_pair: assert property (
        conv_trigger_o && !($past(pseudo_diff_mode_i) && $past(auto_channel_select_i))
        |-> channel_pair_o == $past(manual_pair_i)) else $error("manual pair ignored");
    chk_trigger_busy: assert property (
        conv_trigger_o |-> busy_o ##1 !conv_trigger_o) else $error("trigger without busy");
    chk_last_valid: assert property (
        serial_out_last_o |-> serial_out_valid_o) else $error("last beat not valid");
endmodule : adc_ctrl_properties
////////////////////////////////////////////////////////////////////////////////
bind adc_refdac_sequencer_fifo_ctrl adc_ctrl_properties u_props (.core_clk_i, .reset_n_i,
    .reg_access_i, .access_code_i, .reg_wr_data_i, .reg_rd_data_o, .reg_rd_valid_o,
    .pseudo_diff_mode_i, .auto_channel_select_i, .manual_pair_i, .conv_trigger_o,
    .channel_pair_o, .busy_o, .reference_output_one_enable_o,
    .reference_output_two_enable_o, .serial_out_valid_o, .serial_out_last_o);

//--- bench/adc_refdac_sequencer_fifo_ctrl_bench.sv
`timescale 1ns/1ns
module adc_refdac_sequencer_fifo_ctrl_bench
    import adc_ctrl_pkg::*;
;
    word_t      reg_wr_data_i, reg_rd_data_o, result_a_i, result_b_i;
    word_t      serial_out_a_o, serial_out_b_o;
    code2_t     manual_pair_i, channel_pair_o;
    logic [3:0] access_code_i, conv_delay;
    logic [9:0] reference_output_one_code_o, reference_output_two_code_o;
    logic [7:0] nconv;
    logic       core_clk_i, reset_n_i, reg_access_i, reg_rd_valid_o, pseudo_diff_mode_i;
    logic       auto_channel_select_i, half_clock_mode_i, fifo_enable_bit_i, conv_done_i;
    logic       conversion_start_strobe_i, read_strobe_i, conv_trigger_o, busy_o;
    logic       reference_output_one_enable_o, reference_output_two_enable_o;
    logic       serial_out_valid_o, serial_out_last_o, conv_req, read_req;
    int         errors, samples_checked;
    code2_t     pairs[$];
    pair_word_t beats[$];
    adc_refdac_sequencer_fifo_ctrl DUT (.core_clk_i, .reset_n_i, .reg_access_i,
        .access_code_i, .reg_wr_data_i, .reg_rd_data_o, .reg_rd_valid_o, .pseudo_diff_mode_i,
        .auto_channel_select_i, .half_clock_mode_i, .fifo_enable_bit_i, .manual_pair_i,
        .conversion_start_strobe_i, .read_strobe_i, .conv_done_i, .result_a_i, .result_b_i,
        .conv_trigger_o, .channel_pair_o, .busy_o, .reference_output_one_enable_o,
        .reference_output_one_code_o, .reference_output_two_enable_o,
        .reference_output_two_code_o, .serial_out_a_o, .serial_out_b_o,
        .serial_out_valid_o, .serial_out_last_o);
    host_strobe_model host (.core_clk_i, .conv_req_i(conv_req), .read_req_i(read_req),
        .conv_strobe_o(conversion_start_strobe_i), .read_strobe_o(read_strobe_i));
    ////////////////////////////////////////////////////////////////////////////////
    // Engine stand-in: result k carries k
    assign result_a_i = {8'hA0, nconv};
    assign result_b_i = {8'hB0, nconv};
    always @(posedge core_clk_i) begin
        conv_delay <= {conv_delay[2:0], conv_trigger_o};
        conv_done_i <= conv_delay[3];
        nconv <= nconv + {7'h00, conv_done_i};
        if (conv_trigger_o) pairs.push_back(channel_pair_o);
        if (serial_out_valid_o) beats.push_back({serial_out_a_o, serial_out_b_o});
    end
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    function automatic pair_word_t pw(input logic [7:0] k);
        return {8'hA0, k, 8'hB0, k};
    endfunction : pw
    task automatic reg_op(input logic [3:0] code, input word_t data);
        reg_access_i <= 1'b1;
        access_code_i <= code;
        reg_wr_data_i <= data;
        @(posedge core_clk_i);
        reg_access_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : reg_op
    task automatic rd(input logic [3:0] code, input word_t exp);
        reg_op(code, 16'h0000);
        cmp("register read", exp, reg_rd_data_o);
    endtask : rd
    // Strobe, then bounded wait for the results
    task automatic run(input logic read, input int nc, input int nb);
        int n = 0;
        conv_req <= !read;
        read_req <= read;
        @(posedge core_clk_i);
        {conv_req, read_req} <= 2'h0;
        while ((nconv < nc || busy_o || serial_out_valid_o || beats.size() < nb) && n < 300)
        begin
            @(posedge core_clk_i);
            n++;
        end
        if (n == 300) begin
            errors++;
            stop_test();
        end
    endtask : run
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_registers();
        cmp("dac one code", 10'h3FF, reference_output_one_code_o);
        rd(4'h3, 16'h07FF);
        rd(4'hB, 16'h0000);
        reg_op(4'h2, 16'h0155);
        reg_op(4'hD, 16'h06AA);
        cmp("dac one enable", 1'b1, reference_output_one_enable_o);
        rd(4'h3, 16'h0155);
        rd(4'h6, 16'h06AA);
        cmp("dac two code", 10'h2AA, reference_output_two_code_o);
        reg_op(4'h8, 16'h1234);
        cmp("ignored code", 16'h06AA, reg_rd_data_o);
    endtask : check_registers
    task automatic check_manual();
        run(1'b0, 1, 0);
        run(1'b1, 1, 1);
        cmp("manual pair", 2'h2, pairs[0]);
        cmp("single beat", pw(0), beats[0]);
    endtask : check_manual
    task automatic check_fifo();
        fifo_enable_bit_i <= 1'b1;
        reg_op(4'h9, 16'h0001);
        beats.delete();
        for (int k = 2; k <= 4; k++) run(1'b0, k, 0);
        run(1'b1, 4, 2);
        cmp("fifo beats", 2, beats.size());
        cmp("oldest kept", pw(2), beats[0]);
        cmp("newest", pw(3), beats[1]);
    endtask : check_fifo
    task automatic check_sequence();
        {pseudo_diff_mode_i, auto_channel_select_i, half_clock_mode_i} <= 3'h7;
        fifo_enable_bit_i <= 1'b0;
        reg_op(4'h9, 16'hDD00);
        pairs.delete();
        beats.delete();
        run(1'b0, 6, 0);
        cmp("slot one pair", 2'h3, pairs[0]);
        cmp("slot two pair", 2'h1, pairs[1]);
        run(1'b1, 6, 2);
        cmp("sequence beats", 2, beats.size());
        cmp("slot one word", pw(4), beats[0]);
        cmp("slot two word", pw(5), beats[1]);
        rd(4'hB, 16'hDD00);
        fifo_enable_bit_i <= 1'b1;
        reg_op(4'h9, 16'h9D01);
        beats.delete();
        run(1'b0, 8, 0);
        run(1'b0, 10, 0);
        run(1'b1, 10, 4);
        cmp("cleared", 0, beats[0]);
        cmp("fifo slot two", pw(9), beats[3]);
    endtask : check_sequence
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_n_i, reg_access_i, pseudo_diff_mode_i, auto_channel_select_i} = 4'h0;
        {half_clock_mode_i, fifo_enable_bit_i, conv_req, read_req, conv_done_i} = 5'h00;
        {access_code_i, conv_delay, nconv, reg_wr_data_i} = 32'h00000000;
        {errors, samples_checked, manual_pair_i} = 66'h2;
        repeat (4) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        @(posedge core_clk_i);
        check_registers();
        check_manual();
        check_fifo();
        check_sequence();
        stop_test();
    end
endmodule : adc_refdac_sequencer_fifo_ctrl_bench
